// >>> iommu_ctrl_enable_update.sv
// Purpose: Control register with per-field acknowledge twin of an I/O translation unit
// Assumes: Single clock; register port is a simple read/write strobe port
// Notes: Each field runs its own update engine; drains come from the datapath
//
// Operation
// - Command-queue enable bit3 gates command processing
// - Event-queue enable bit2 gates event writes
// - Page-request enable bit1, reserved without support
// - Translation enable bit0: bypass or check
// - Control register read/write at offset 0x20
// - Every field has independent acknowledge twin
// - Update finishes in bounded time, side-effects first
// - Old value used until update, except cmdq/evq/prq disables act at once; reads immediate
// - Rewrite during update taken at completion, or cancels
// - Wildcard update waits for invalidations drained
// - ATS check update waits for new handling
// - Command disable ack waits fetch/read stop
// - Consume commands when enabled, non-empty, errorless
// - Event disable ack waits records, abort flag
// - Effective page-request enable qualified by translation
// - Page-request disable ack waits committed records
// - Translation clear forces page requests dropped
`include "ctrl_update_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module iommu_ctrl_enable_update
    import ctrl_update_pkg::*;
#(
    parameter bit PRQ_SUPPORTED = 1'b1, // Page-request support present
    parameter int SETTLE_CYCLES = `SETTLE_CYC // Least settle time per update
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic srst_i,
    // Register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    output logic [31:0] reg_rdata_o,
    output logic reg_err_o,
    // Datapath drain status
    input wire logic cmdq_idle_i,
    input wire logic evq_idle_i,
    input wire logic prq_idle_i,
    input wire logic tlbi_idle_i,
    input wire logic cfg_idle_i,
    input wire logic cmdq_nonempty_i,
    input wire logic cmdq_error_i,
    // Effective enables to the datapath
    output logic cmdq_fetch_en_o,
    output logic evq_write_en_o,
    output logic prq_write_en_o,
    output logic prq_drop_o,
    output logic translate_en_o,
    output logic bypass_o,
    output logic ats_check_o,
    output logic [2:0] vmid_wildcard_o
);
    // ==========================================================
    // Field indexes: 0 trans, 1 prq, 2 evq, 3 cmdq, 4 ats, 5 vmw
    localparam int NF = 6;
    localparam logic [3:0] SETTLE = 4'(SETTLE_CYCLES);

    logic [31:0] control; // Value software wrote
    logic [2:0] ack_vmw; // Acknowledged wildcard
    logic [NF-2:0] ack_bit; // Acknowledged one-bit fields
    logic [2:0] eff_vmw; // Value in use
    logic [NF-2:0] eff_bit; // Values in use
    fld_state_type state [NF]; // Engine per field
    logic [3:0] cnt [NF]; // Settle counter per field
    logic [NF-1:0] drained; // Side-effects finished per field

    // Decode
    wire hit_ctl = reg_addr_i == `OFS_CONTROL;
    wire hit_ack = reg_addr_i == `OFS_CONTROL_ACK;
    wire wr_ctl = reg_wr_i && hit_ctl;
    wire [31:0] wmask = {23'h0, 3'h7, 1'h0, 1'h1, 2'h3, PRQ_SUPPORTED, 1'h1};
    wire [31:0] ack_word = {23'h0, ack_vmw, 1'h0, ack_bit[4], ack_bit[3:0]};

    // Per-field drain conditions
    assign drained[0] = prq_idle_i && cfg_idle_i;
    assign drained[1] = prq_idle_i;
    assign drained[2] = evq_idle_i;
    assign drained[3] = cmdq_idle_i;
    assign drained[4] = cfg_idle_i;
    assign drained[5] = tlbi_idle_i;

    // Field value pickers
    function automatic logic [2:0] fld_get(input logic [31:0] w, input int f);
        if (f == 5) begin
            fld_get = w[`MSB_VMW:`LSB_VMW];
        end else if (f == 4) begin
            fld_get = {2'h0, w[`BIT_ATS_CHK]};
        end else begin
            fld_get = {2'h0, w[f]};
        end
    endfunction

    // ==========================================================
    // Control register; reads return written value at once
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            control <= `RST_CONTROL;
        end else if (wr_ctl) begin
            control <= reg_wdata_i & wmask;
        end
    end

    // Read mux, registered data
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            reg_rdata_o <= 32'h0;
            reg_err_o <= 1'b0;
        end else begin
            reg_rdata_o <= !reg_rd_i ? 32'h0 : hit_ctl ? control : hit_ack ? ack_word : 32'h0;
            reg_err_o <= (reg_rd_i && !hit_ctl && !hit_ack) || (reg_wr_i && !hit_ctl);
        end
    end

    // ==========================================================
    // Independent update engines
    for (genvar f = 0; f < NF; f++) begin : g_fld
        wire [2:0] want = fld_get(control, f);
        // Index folded so the wildcard engine never names a missing one-bit twin
        wire [2:0] ackv = (f == 5) ? ack_vmw : {2'h0, ack_bit[(f == 5) ? 0 : f]};
        // Engine keeps only state and settle count; old value held in eff_bit/eff_vmw while draining
        always_ff @(posedge clk_sys_i) begin
            if (srst_i) begin
                state[f] <= FLD_IDLE;
                cnt[f] <= 4'h0;
            end else begin
                unique case (state[f])
                    FLD_IDLE: begin
                        if (want != ackv) begin
                            state[f] <= FLD_DRAIN;
                            cnt[f] <= 4'h0;
                        end
                    end
                    FLD_DRAIN: begin
                        if (want == ackv) begin
                            state[f] <= FLD_IDLE;
                        end else if (cnt[f] >= SETTLE && drained[f]) begin
                            state[f] <= FLD_DONE;
                        end else if (cnt[f] < SETTLE) begin
                            cnt[f] <= cnt[f] + 4'h1;
                        end
                    end
                    FLD_DONE: begin
                        state[f] <= FLD_IDLE;
                    end
                endcase
            end
        end
    end

    // ==========================================================
    // Effective values switch when leaving drain, ack a cycle later
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            eff_bit <= 5'h0;
            eff_vmw <= `RST_VMW;
            ack_bit <= 5'h0;
            ack_vmw <= `RST_VMW;
        end else begin
            for (int f = 0; f < NF - 1; f++) begin
                if (state[f] == FLD_DRAIN && cnt[f] >= SETTLE && drained[f] && control[f == 4 ? 4 : f] != ack_bit[f]) begin
                    eff_bit[f] <= control[f == 4 ? 4 : f];
                end
                if (state[f] == FLD_DONE) begin
                    ack_bit[f] <= eff_bit[f];
                end
            end
            if (state[5] == FLD_DRAIN && cnt[5] >= SETTLE && drained[5] && control[8:6] != ack_vmw) begin
                eff_vmw <= control[`MSB_VMW:`LSB_VMW];
            end
            if (state[5] == FLD_DONE) begin
                ack_vmw <= eff_vmw;
            end
        end
    end

    // ==========================================================
    // Effective enables; fetch stops at once on a disable write
    assign translate_en_o = eff_bit[0];
    assign bypass_o = !eff_bit[0];
    assign cmdq_fetch_en_o = eff_bit[3] && control[`BIT_CMDQ_EN] && cmdq_nonempty_i && !cmdq_error_i;
    assign evq_write_en_o = eff_bit[2] && control[`BIT_EVQ_EN];
    assign prq_write_en_o = eff_bit[1] && eff_bit[0] && control[`BIT_PRQ_EN] && control[`BIT_TRANS_EN];
    assign prq_drop_o = !prq_write_en_o;
    assign ats_check_o = eff_bit[4];
    assign vmid_wildcard_o = eff_vmw;
endmodule // iommu_ctrl_enable_update
`default_nettype wire

// >>> ctrl_update_cfg.svh
// Purpose: Offsets, field positions, reset values and counts of the control register bank
// Assumes: 32-bit register port, byte offsets on word boundaries
// Notes: Definitions only
`ifndef CTRL_UPDATE_CFG_SVH
`define CTRL_UPDATE_CFG_SVH
// ==========================================================
// Register offsets
`define OFS_CONTROL 12'h020
`define OFS_CONTROL_ACK 12'h024
// ==========================================================
// Field positions
`define BIT_TRANS_EN 0
`define BIT_PRQ_EN 1
`define BIT_EVQ_EN 2
`define BIT_CMDQ_EN 3
`define BIT_ATS_CHK 4
`define LSB_VMW 6
`define MSB_VMW 8
// ==========================================================
// Reset values
`define RST_CONTROL 32'h0000_0000
`define RST_VMW 3'h0
// ==========================================================
// Timing
`define SETTLE_NS 40
`define CLK_NS 10
`define SETTLE_CYC ((`SETTLE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// >>> ctrl_update_pkg.sv
// Purpose: Types of the control register bank
// Assumes: Constants live in ctrl_update_cfg.svh
// Notes: One-hot states of the per-field update engine
package ctrl_update_pkg;
    // ==========================================================
    // Per-field update state
    typedef enum logic [2:0] {
        FLD_IDLE = 3'h1, // Field settled
        FLD_DRAIN = 3'h2, // Waiting for side-effects
        FLD_DONE = 3'h4 // Acknowledge taken over
    } fld_state_type;
endpackage

// >>> iommu_ctrl_enable_update_properties.sv
// Purpose: Port-level assertions of the control bank
// Assumes: One clock domain, sync reset
// Notes: Sees only the top module's ports
`timescale 1ns/1ns
`default_nettype none
module iommu_ctrl_enable_update_properties (
    // Watched ports
    input wire logic clk_sys_i, srst_i, reg_wr_i, reg_rd_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i, reg_rdata_o,
    input wire logic reg_err_o, tlbi_idle_i, cmdq_fetch_en_o, evq_write_en_o,
    input wire logic prq_write_en_o, prq_drop_o, translate_en_o, bypass_o,
    input wire logic [2:0] vmid_wildcard_o
);
    // ====
    // Common clock and reset
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    // Control write then control read on the next edge
    sequence ctl_wr_rd;
        reg_wr_i && reg_addr_i == 12'h020 ##1 reg_rd_i && !reg_wr_i && reg_addr_i == 12'h020;
    endsequence
    // ====
    // Assertions
    bypass_inverse_a: assert property (bypass_o == !translate_en_o) else $error("bypass wrong");
    prq_gated_a: assert property (!translate_en_o |-> prq_drop_o && !prq_write_en_o) else $error("prq open");
    prq_drop_a: assert property (prq_drop_o == !prq_write_en_o) else $error("drop wrong");
    ctl_readback_a: assert property (ctl_wr_rd |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 32'h1df))
        else $error("readback wrong");
    ack_ro_a: assert property (reg_wr_i && reg_addr_i != 12'h020 |=> reg_err_o) else $error("no error");
    resv_zero_a: assert property (reg_rdata_o[31:9] == 23'h0 && !reg_rdata_o[5]) else $error("reserved set");
    cmdq_stop_a: assert property (reg_wr_i && reg_addr_i == 12'h020 && !reg_wdata_i[3] |=> !cmdq_fetch_en_o)
        else $error("fetch on");
    evq_stop_a: assert property (reg_wr_i && reg_addr_i == 12'h020 && !reg_wdata_i[2] |=> !evq_write_en_o)
        else $error("events on");
    vmw_drain_a: assert property ($changed(vmid_wildcard_o) |-> $past(tlbi_idle_i)) else $error("early vmw");
endmodule // iommu_ctrl_enable_update_properties
`default_nettype wire

// >>> iommu_ctrl_enable_update_bench.sv
// Purpose: Register-level test of the control bank
// Assumes: Drain inputs driven by the bench
// Notes: Ack polled with bounded loops
`include "ctrl_update_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, x, g) begin comparisons++; if ((g) !== (x)) begin errors++; $display("wrong value %s %h %h", n, x, g); end end
module iommu_ctrl_enable_update_bench;
    import ctrl_update_pkg::*;
    // ====
    // Stimulus and observed signals
    logic clk_sys_i = 1'b0, srst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, reg_err_o, e;
    logic [11:0] reg_addr_i = 12'h000;
    logic [31:0] reg_wdata_i = 32'h0, reg_rdata_o, d;
    logic cmdq_idle_i = 1'b1, evq_idle_i = 1'b1, prq_idle_i = 1'b1, tlbi_idle_i = 1'b1, cfg_idle_i = 1'b1;
    logic cmdq_nonempty_i = 1'b1, cmdq_error_i = 1'b0, cmdq_fetch_en_o, evq_write_en_o, prq_write_en_o;
    logic prq_drop_o, translate_en_o, bypass_o, ats_check_o;
    logic [2:0] vmid_wildcard_o;
    int errors = 0, comparisons = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    iommu_ctrl_enable_update DUT (.*);
    // ====
    // Access tasks; a write holds its strobe until the next read task
    task automatic print_verdict();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= v;
    endtask
    task automatic rd(input logic [11:0] a);
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
        e = reg_err_o;
    endtask
    // Bounded poll of the acknowledge word
    task automatic poll(input logic [31:0] x);
        for (int i = 0; i < 40; i++) begin
            rd(`OFS_CONTROL_ACK);
            if (d === x) break;
        end
        `CHK("ack", x, d)
        if (d !== x) print_verdict();
    endtask
    // ====
    // Main sequence
    initial begin
        repeat (2) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        rd(`OFS_CONTROL); `CHK("ctrl", 32'h0, d)
        rd(`OFS_CONTROL_ACK); `CHK("ack", 32'h0, d)
        `CHK("bypass", 1'b1, bypass_o)
        tlbi_idle_i <= 1'b0;
        wr(`OFS_CONTROL, 32'hffff_ff3f);
        rd(`OFS_CONTROL); `CHK("ctrl", 32'h11f, d)
        repeat (20) @(posedge clk_sys_i);
        rd(`OFS_CONTROL_ACK); `CHK("ack", 32'h01f, d)
        tlbi_idle_i <= 1'b1;
        poll(32'h11f);
        `CHK("en", 5'h1f, {cmdq_fetch_en_o, evq_write_en_o, prq_write_en_o, translate_en_o, ats_check_o})
        `CHK("vmw", 3'h4, vmid_wildcard_o)
        cmdq_error_i <= 1'b1;
        rd(`OFS_CONTROL); `CHK("fetch", 1'b0, cmdq_fetch_en_o)
        cmdq_error_i <= 1'b0;
        wr(`OFS_CONTROL, 32'h11e);
        poll(32'h11e);
        `CHK("prq", 3'b011, {prq_write_en_o, prq_drop_o, bypass_o})
        // Rewrite back to the old value before completion cancels it
        wr(`OFS_CONTROL, 32'h11f);
        wr(`OFS_CONTROL, 32'h11e);
        rd(`OFS_CONTROL);
        repeat (20) @(posedge clk_sys_i);
        rd(`OFS_CONTROL_ACK); `CHK("cancel", 33'h0_11e, {translate_en_o, d})
        cmdq_idle_i <= 1'b0;
        wr(`OFS_CONTROL, 32'h116);
        rd(`OFS_CONTROL); `CHK("fetch", 1'b0, cmdq_fetch_en_o)
        repeat (20) @(posedge clk_sys_i);
        rd(`OFS_CONTROL_ACK); `CHK("cmdq ack", 1'b1, d[3])
        cmdq_idle_i <= 1'b1;
        poll(32'h116);
        wr(`OFS_CONTROL_ACK, 32'h0);
        rd(12'h028); `CHK("err", 1'b1, e)
        rd(`OFS_CONTROL_ACK); `CHK("ack ro", 32'h116, d)
        wr(`OFS_CONTROL, 32'h0);
        rd(`OFS_CONTROL); `CHK("evq", 1'b0, evq_write_en_o)
        print_verdict();
    end
endmodule // iommu_ctrl_enable_update_bench
bind iommu_ctrl_enable_update iommu_ctrl_enable_update_properties chk (.*);
`default_nettype wire
